/* File: hdl/sfmc_regs.svh */
// Constants for the serial flash mode and control front end.
`ifndef SFMC_REGS_SVH
`define SFMC_REGS_SVH
// Instruction codes.
`define SFMC_OP_WREN 8'h06
`define SFMC_OP_WRDI 8'h04
`define SFMC_OP_WRSR 8'h01
`define SFMC_OP_PP 8'h02
`define SFMC_OP_QPP 8'h32
`define SFMC_OP_SE 8'h20
`define SFMC_OP_BE32 8'h52
`define SFMC_OP_BE64 8'hd8
`define SFMC_OP_CE 8'hc7
`define SFMC_OP_DOR 8'h3b
`define SFMC_OP_DIOR 8'hbb
`define SFMC_OP_DID 8'h92
`define SFMC_OP_QOR 8'h6b
`define SFMC_OP_QIOR 8'heb
`define SFMC_OP_QWR 8'he7
`define SFMC_OP_QID 8'h94
`define SFMC_OP_ENQ 8'h38
`define SFMC_OP_EXQ 8'hff
`define SFMC_OP_RSTEN 8'h66
`define SFMC_OP_RST 8'h99
`define SFMC_OP_DPD 8'hb9
`define SFMC_OP_RDP 8'hab
// Timing, in ns, and cycle counts at 4 ns per cycle.
`define SFMC_CLK_NS 4
`define SFMC_PU_WRITE_DELAY_NS 1000000
`define SFMC_SOFT_CLEAR_NS 30000
`define SFMC_PIN_CLEAR_MIN_NS 1000
`define SFMC_PU_WRITE_CYC (`SFMC_PU_WRITE_DELAY_NS / `SFMC_CLK_NS)
`define SFMC_SOFT_CLEAR_CYC (`SFMC_SOFT_CLEAR_NS / `SFMC_CLK_NS)
`define SFMC_PIN_CLEAR_CYC ((`SFMC_PIN_CLEAR_MIN_NS + `SFMC_CLK_NS - 1) / `SFMC_CLK_NS)
`endif

/* File: hdl/sfmc_pkg.sv */
// Types shared by the serial flash mode and control front end.
package sfmc_pkg;
    typedef enum logic [1:0] {SFMC_W1, SFMC_W2, SFMC_W4} sfmc_width_t;
endpackage

/* File: hdl/sfmc_sync_if.sv */
// Synchronised pin levels passed from the synchroniser to the controller.
`timescale 1ns/10ps
interface sfmc_sync_if;
    logic sck;
    logic cs_n;
    logic [3:0] io;
    modport src (output sck, output cs_n, output io);
    modport dst (input sck, input cs_n, input io);
endinterface // sfmc_sync_if

/* File: hdl/sfmc_sync.sv */
// Two-flop synchronisers for every bus pin.
`timescale 1ns/10ps
module sfmc_sync #(
    parameter int N = 6,
    parameter logic [N-1:0] RST_LEVEL = '1
) (
    input wire logic ref_clk, // Core clock.
    input wire logic arst_n, // Asynchronous reset.
    input wire logic [N-1:0] pins, // Raw pin levels.
    sfmc_sync_if.src syn // Synchronised levels.
);
    logic [N-1:0] s1_ff;
    logic [N-1:0] s2_ff;
    // Each pin resets to the level chosen by the parent, so its edge detector sees no false edge.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_ff <= RST_LEVEL;
            s2_ff <= RST_LEVEL;
        end else begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
        end
    end
    assign syn.sck = s2_ff[0];
    assign syn.cs_n = s2_ff[1];
    assign syn.io = s2_ff[5:2];
endmodule // sfmc_sync

/* File: hdl/sfmc_top.sv */
// Mode, select, pause, reset and write-enable control of a serial flash front end.
`timescale 1ns/10ps
`include "sfmc_regs.svh"
module sfmc_top #(
    parameter int PU_WRITE_CYC = `SFMC_PU_WRITE_CYC,
    parameter int SOFT_CLEAR_CYC = `SFMC_SOFT_CLEAR_CYC
) (
    input wire logic ref_clk, // Core clock, 250 MHz.
    input wire logic arst_n, // Power-on reset, active low.
    input wire logic sck, // Bus clock pin.
    input wire logic cs_n, // Chip select pin.
    input wire logic [3:0] io_in, // Data line levels.
    output logic [3:0] io_out, // Data line drive values.
    output logic [3:0] io_oe_n, // Data line enables, low drives.
    input wire logic quad_enable, // Non-volatile quad enable.
    input wire logic pause_or_clear_select, // 1: line 3 is pin reset.
    input wire logic srp0, // Hardware status protection configured.
    input wire logic srp1, // Status lock-down configured.
    input wire logic area_hit, // Addressed area lies in area_guard_bits range.
    input wire logic write_busy, // Internal write cycle running.
    input wire logic [7:0] tx_byte, // Read data byte to send.
    output logic [7:0] opcode, // Last accepted instruction.
    output logic op_strobe, // Pulse when an instruction is accepted.
    output logic write_go, // Pulse: permitted program/erase/status write.
    output logic write_latch, // Write enable latch.
    output logic four_wire_instruction_mode, // Instruction mode flag.
    output logic paused, // Pause in effect.
    output logic deep_down, // Deep power-down state.
    output logic standby, // Standby state.
    output logic selected, // Active selected state.
    output logic busy_reset // Reset in progress.
);
    sfmc_sync_if syn ();
    logic [7:0] sr_ff;
    logic [3:0] bitcnt_ff;
    logic sck_d_ff, cs_d_ff, armed_ff, pause_ff, qpi_ff, wel_ff, dpd_ff, rsten_ff, done_ff;
    logic pin_rst_ff, op_ff_v, go_ff, busy_ff;
    logic [7:0] op_ff;
    logic [31:0] pu_cnt_ff, rst_cnt_ff, pin_cnt_ff;
    logic [3:0] out_ff;
    sfmc_pkg::sfmc_width_t wmode_ff;

    // Chip select resets low: a select held low through power-up then shows no falling edge.
    // The price is that a select high at power-up is seen low for two cycles, which is harmless.
    sfmc_sync #(.N(6), .RST_LEVEL(6'h3d)) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pins({io_in, cs_n, sck}),
        .syn(syn)
    );

    // Four-line reads; quad page program is decoded with the write class.
    function automatic logic quad_read(input logic [7:0] c);
        return c == `SFMC_OP_QOR || c == `SFMC_OP_QIOR || c == `SFMC_OP_QWR || c == `SFMC_OP_QID;
    endfunction

    // =====================================================================
    // Edge detection on synchronised levels.
    wire rise = syn.sck && !sck_d_ff;
    wire fall = !syn.sck && sck_d_ff;
    wire cs_fall = !syn.cs_n && cs_d_ff;
    wire pin_ctl = !quad_enable;
    wire pause_en = pin_ctl && !pause_or_clear_select;
    wire clear_en = pin_ctl && pause_or_clear_select;
    wire clear_low = clear_en && !syn.io[3];
    wire clear_fire = clear_low && pin_cnt_ff >= `SFMC_PIN_CLEAR_CYC - 1;
    wire pu_done = pu_cnt_ff >= PU_WRITE_CYC;
    wire live = armed_ff && !syn.cs_n && !pause_ff && !busy_ff && !clear_low;
    wire [7:0] nxt_sr = qpi_ff ? {sr_ff[3:0], syn.io} : {sr_ff[6:0], syn.io[0]};
    // The counter counts bus clocks, so four-wire mode ends after its second clock.
    wire [3:0] last_bit = qpi_ff ? 4'd1 : 4'd7;
    wire op_done = live && rise && !done_ff && bitcnt_ff == last_bit;
    wire hw_lock = (srp0 && !srp1 && !syn.io[2] && pin_ctl) || srp1;
    // Decode of the instruction just completed.
    wire is_wren = nxt_sr == `SFMC_OP_WREN;
    wire is_wrsr = nxt_sr == `SFMC_OP_WRSR;
    wire is_pgm = nxt_sr == `SFMC_OP_PP || (nxt_sr == `SFMC_OP_QPP && quad_enable);
    wire is_ers = nxt_sr == `SFMC_OP_SE || nxt_sr == `SFMC_OP_BE32 || nxt_sr == `SFMC_OP_BE64
        || nxt_sr == `SFMC_OP_CE;
    wire is_dual = nxt_sr == `SFMC_OP_DOR || nxt_sr == `SFMC_OP_DIOR || nxt_sr == `SFMC_OP_DID;
    wire is_quad = quad_enable && quad_read(nxt_sr);
    // Quad instructions and the four-wire entry are dropped without quad_enable.
    wire quad_refused = !quad_enable && (quad_read(nxt_sr) || nxt_sr == `SFMC_OP_QPP
        || nxt_sr == `SFMC_OP_ENQ);
    wire is_wr_cls = is_wren || is_wrsr || is_pgm || is_ers;
    wire dpd_block = dpd_ff && nxt_sr != `SFMC_OP_RDP;
    wire accept = op_done && !dpd_block && !quad_refused && !(is_wr_cls && !pu_done);
    wire wr_ok = wel_ff && (is_wrsr ? !hw_lock : !area_hit);
    wire soft_rst = accept && rsten_ff && nxt_sr == `SFMC_OP_RST;
    wire drive = !syn.cs_n && !pause_ff && wmode_ff != sfmc_pkg::SFMC_W1;

    // =====================================================================
    // Bus-side state: select, pause and instruction shift.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_d_ff <= 1'b1;
            cs_d_ff <= 1'b0;
            armed_ff <= 1'b0;
            pause_ff <= 1'b0;
            sr_ff <= 8'h00;
            bitcnt_ff <= 4'h0;
            done_ff <= 1'b0;
        end else begin
            sck_d_ff <= syn.sck;
            cs_d_ff <= syn.cs_n;
            if (cs_fall) begin
                armed_ff <= 1'b1;
            end
            // Pause edges are only honoured with the bus clock low.
            if (!pause_en || syn.cs_n) begin
                pause_ff <= 1'b0;
            end else if (!syn.sck) begin
                pause_ff <= !syn.io[3];
            end
            if (syn.cs_n || pin_rst_ff || busy_ff || soft_rst) begin
                bitcnt_ff <= 4'h0;
                done_ff <= 1'b0;
                sr_ff <= 8'h00;
            end else if (live && rise && !done_ff) begin
                sr_ff <= nxt_sr;
                bitcnt_ff <= op_done ? 4'h0 : bitcnt_ff + 4'h1;
                done_ff <= op_done;
            end
        end
    end

    // =====================================================================
    // Device state: modes, latch, power-up and reset timers.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            qpi_ff <= 1'b0;
            wel_ff <= 1'b0;
            dpd_ff <= 1'b0;
            rsten_ff <= 1'b0;
            op_ff <= 8'h00;
            op_ff_v <= 1'b0;
            go_ff <= 1'b0;
            wmode_ff <= sfmc_pkg::SFMC_W1;
            busy_ff <= 1'b0;
            pin_rst_ff <= 1'b0;
            pu_cnt_ff <= 32'h0;
            rst_cnt_ff <= 32'h0;
            pin_cnt_ff <= 32'h0;
        end else begin
            op_ff_v <= accept;
            go_ff <= 1'b0;
            // The reset instruction is reported as well, so the opcode follows every accept pulse.
            if (accept) begin
                op_ff <= nxt_sr;
            end
            if (!pu_done) begin
                pu_cnt_ff <= pu_cnt_ff + 32'h1;
            end
            pin_cnt_ff <= clear_low ? pin_cnt_ff + 32'h1 : 32'h0;
            pin_rst_ff <= clear_fire || (pin_rst_ff && clear_low);
            if (syn.cs_n) begin
                wmode_ff <= sfmc_pkg::SFMC_W1;
            end
            if (clear_fire || pin_rst_ff) begin
                qpi_ff <= 1'b0;
                wel_ff <= 1'b0;
                dpd_ff <= 1'b0;
                rsten_ff <= 1'b0;
                wmode_ff <= sfmc_pkg::SFMC_W1;
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                rst_cnt_ff <= rst_cnt_ff + 32'h1;
                if (rst_cnt_ff >= SOFT_CLEAR_CYC - 1) begin
                    busy_ff <= 1'b0;
                end
            end else if (soft_rst) begin
                qpi_ff <= 1'b0;
                wel_ff <= 1'b0;
                dpd_ff <= 1'b0;
                rsten_ff <= 1'b0;
                busy_ff <= 1'b1;
                rst_cnt_ff <= 32'h0;
            end else if (accept) begin
                rsten_ff <= nxt_sr == `SFMC_OP_RSTEN;
                if (nxt_sr == `SFMC_OP_ENQ && quad_enable) begin
                    qpi_ff <= 1'b1;
                end
                if (nxt_sr == `SFMC_OP_EXQ) begin
                    qpi_ff <= 1'b0;
                end
                if (nxt_sr == `SFMC_OP_DPD) begin
                    dpd_ff <= 1'b1;
                end
                if (nxt_sr == `SFMC_OP_RDP) begin
                    dpd_ff <= 1'b0;
                end
                if (is_wren) begin
                    wel_ff <= 1'b1;
                end
                if (nxt_sr == `SFMC_OP_WRDI || is_wrsr || is_pgm || is_ers) begin
                    wel_ff <= 1'b0;
                end
                go_ff <= (is_wrsr || is_pgm || is_ers) && wr_ok;
                // In four-wire mode only reads turn the lines round; writes keep taking data in.
                if (is_quad || (qpi_ff && is_dual)) begin
                    wmode_ff <= sfmc_pkg::SFMC_W4;
                end else if (is_dual) begin
                    wmode_ff <= sfmc_pkg::SFMC_W2;
                end else begin
                    wmode_ff <= sfmc_pkg::SFMC_W1;
                end
            end
        end
    end

    // =====================================================================
    // Output data changes on the falling bus clock edge.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_ff <= 4'h0;
        end else if (fall && !pause_ff) begin
            out_ff <= wmode_ff == sfmc_pkg::SFMC_W4 ? tx_byte[7:4] : {2'b00, tx_byte[7:6]};
        end
    end

    // Line 1 carries serial output; enables follow the transfer width.
    assign io_out = out_ff;
    // Serial output on line 1 is kept off in four-wire mode, where the host may still drive it.
    assign io_oe_n[0] = !drive;
    assign io_oe_n[1] = !drive && !(live && done_ff && !qpi_ff);
    assign io_oe_n[3:2] = drive && wmode_ff == sfmc_pkg::SFMC_W4 ? 2'b00 : 2'b11;
    assign opcode = op_ff;
    assign op_strobe = op_ff_v;
    assign write_go = go_ff;
    assign write_latch = wel_ff;
    assign four_wire_instruction_mode = qpi_ff;
    assign paused = pause_ff;
    assign deep_down = dpd_ff;
    assign selected = armed_ff && !syn.cs_n;
    assign standby = syn.cs_n && !write_busy && !busy_ff;
    assign busy_reset = busy_ff || pin_rst_ff;
endmodule // sfmc_top

/* File: sim/sfmc_top_sva.sv */
// Port-level assertions for the flash mode and control front end.
`timescale 1ns/10ps
`include "sfmc_regs.svh"
module sfmc_top_sva (
    input wire logic ref_clk, // Core clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic [3:0] io_oe_n, // Line enables, low drives.
    input wire logic quad_enable, // Quad enable.
    input wire logic pause_or_clear_select, // Line 3 role.
    input wire logic [7:0] opcode, // Accepted instruction.
    input wire logic op_strobe, // Accept pulse.
    input wire logic write_go, // Write permit pulse.
    input wire logic write_latch, // Write enable latch.
    input wire logic paused, // Pause flag.
    input wire logic deep_down, // Deep power-down.
    input wire logic busy_reset // Reset in progress.
);
    // ==========
    // Checks.
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // An instruction needs at least two bus clocks, so accept pulses never crowd.
    sequence s_quiet;
        ##1 !op_strobe [*2];
    endsequence
    a_strobe_gap: assert property (op_strobe |-> s_quiet)
        else $error("accept pulse too long");
    a_quad_gated: assert property (op_strobe && (opcode == `SFMC_OP_ENQ || opcode == `SFMC_OP_QOR) |-> quad_enable)
        else $error("quad instruction without quad enable");
    a_reset_refuses: assert property (busy_reset && $past(busy_reset) |-> !op_strobe && !write_go)
        else $error("instruction taken during reset");
    a_go_needs_latch: assert property (write_go |-> write_latch || $past(write_latch))
        else $error("write permit without latch");
    a_go_clears_latch: assert property (write_go |-> ##[0:2] !write_latch)
        else $error("latch kept after write");
    a_wren_sets_latch: assert property (op_strobe && opcode == `SFMC_OP_WREN |-> ##[0:2] write_latch)
        else $error("write enable left latch clear");
    a_deep_release: assert property (op_strobe && $past(deep_down, 2) |-> opcode == `SFMC_OP_RDP)
        else $error("instruction taken in deep power-down");
    a_pause_hiz: assert property (paused |-> io_oe_n == 4'hf)
        else $error("line driven while paused");
    a_pause_cond: assert property (paused |-> !$past(quad_enable) && !$past(pause_or_clear_select))
        else $error("pause while disabled");
endmodule // sfmc_top_sva
bind sfmc_top sfmc_top_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n), .io_oe_n(io_oe_n),
    .quad_enable(quad_enable), .pause_or_clear_select(pause_or_clear_select), .opcode(opcode),
    .op_strobe(op_strobe), .write_go(write_go), .write_latch(write_latch), .paused(paused),
    .deep_down(deep_down), .busy_reset(busy_reset));

/* File: sim/sfmc_host.sv */
// Host serial controller model driving the flash bus pins.
`timescale 1ns/10ps
module sfmc_host (
    input wire logic ref_clk, // Core clock used for pacing.
    output logic sck, // Bus clock.
    output logic cs_n, // Chip select.
    output logic [3:0] io // Data lines toward the device.
);
    // ==========
    // Frames.
    // Select starts low so that the first frame meets the power-up select guard.
    initial begin
        sck = 1'b0;
        cs_n = 1'b0;
        io = 4'hc;
    end
    // Ten core cycles per half period give the 80 ns bus clock.
    task automatic half();
        repeat (10) @(posedge ref_clk);
    endtask
    task automatic send(input logic [7:0] op, input bit four, input bit mode3);
        // The clock takes its idle level before select falls, so no edge is counted.
        sck <= mode3;
        half();
        cs_n <= 1'b0;
        half();
        for (int i = (four ? 1 : 7); i >= 0; i--) begin
            sck <= 1'b0;
            if (four) io <= op[i*4 +: 4];
            else io[0] <= op[i];
            half();
            sck <= 1'b1;
            half();
        end
        sck <= mode3;
        half();
        cs_n <= 1'b1;
        // Released lines must not keep their last level; lines 2 and 3 have pull-ups.
        io <= four ? {2'b11, ~io[1:0]} : {io[3:2], ~io[1:0]};
    endtask
    // Sends only the first four bits of an instruction, then deselects.
    task automatic cut(input logic [7:0] op);
        sck <= 1'b0;
        half();
        cs_n <= 1'b0;
        half();
        for (int i = 7; i >= 4; i--) begin
            io[0] <= op[i];
            half();
            sck <= 1'b1;
            half();
            sck <= 1'b0;
        end
        half();
        cs_n <= 1'b1;
        half();
    endtask
    task automatic hold(input logic v, input logic c);
        cs_n <= c;
        sck <= 1'b0;
        half();
        io[3] <= v;
        half();
        half();
    endtask
endmodule // sfmc_host

/* File: sim/sfmc_tb_top.sv */
// Self-checking bench for the flash mode and control front end.
`timescale 1ns/10ps
module sfmc_tb_top;
    logic ref_clk, sck, cs_n, strobe, go, latch, fw, paused, deep, busy, sel, stby;
    logic arst_n = 1'b0, qe = 1'b0, pcs = 1'b0, srp0 = 1'b0, hit = 1'b0;
    logic [3:0] io, io_out, oe_n;
    logic [7:0] op, tx = 8'h00;
    logic [7:0] exp_q[$];
    logic [7:0] rd[8] = '{8'h3b, 8'hbb, 8'h92, 8'h6b, 8'heb, 8'he7, 8'h94, 8'h32};
    int num_errors = 0, samples_checked = 0, gos = 0;
    wire [3:0] io_w = (io_out & ~oe_n) | (io & oe_n);
    sfmc_host host (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n), .io(io));
    sfmc_top #(.PU_WRITE_CYC(500), .SOFT_CLEAR_CYC(300)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .sck(sck),
        .cs_n(cs_n), .io_in(io_w), .io_out(io_out), .io_oe_n(oe_n), .quad_enable(qe), .pause_or_clear_select(pcs),
        .srp0(srp0), .srp1(1'b0), .area_hit(hit), .write_busy(1'b0), .tx_byte(tx), .opcode(op),
        .op_strobe(strobe), .write_go(go), .write_latch(latch), .four_wire_instruction_mode(fw),
        .paused(paused), .deep_down(deep), .standby(stby), .selected(sel), .busy_reset(busy));
    // ==========
    // Checking.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic chk1(input string w, input logic e, input logic s);
        chk(w, {7'h00, e}, {7'h00, s});
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (strobe === 1'b1 && exp_q.size() == 0) chk("stray opcode", 8'hxx, op);
        else if (strobe === 1'b1) chk("opcode", exp_q.pop_front(), op);
        if (go === 1'b1) gos++;
    end
    initial begin
        #80000;
        num_errors++;
        end_sim();
    end
    // ==========
    // Stimulus.
    task automatic do_op(input logic [7:0] c, input bit ok, input bit four);
        bit m3;
        m3 = 1'($urandom_range(1));
        if (ok) exp_q.push_back(c);
        host.send(c, four, m3);
        // Only a mode 0 frame has a falling edge after the instruction, which loads the first output.
        if (ok && !m3 && c inside {8'h3b, 8'hbb, 8'h92}) begin
            chk("dual out", {6'h00, tx[7:6]}, {6'h00, io_out[1:0]});
        end
        if (ok && !m3 && c inside {8'h6b, 8'heb, 8'he7, 8'h94}) begin
            chk("quad out", {4'h0, tx[7:4]}, {4'h0, io_out});
        end
        repeat (8) @(posedge ref_clk);
        chk("released lines", 8'h0f, {4'h0, oe_n});
        tx <= 8'($urandom);
    endtask
    initial begin
        void'($urandom(97665));
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk1("select guard", 1'b0, sel);
        do_op(8'h3b, 0, 0);
        do_op(8'h06, 0, 0);
        chk1("early latch", 1'b0, latch);
        chk1("standby", 1'b1, stby);
        repeat (500) @(posedge ref_clk);
        do_op(8'h06, 1, 0);
        chk1("latch set", 1'b1, latch);
        do_op(8'h02, 1, 0);
        chk1("latch after program", 1'b0, latch);
        do_op(8'h02, 1, 0);
        hit <= 1'b1;
        do_op(8'h06, 1, 0);
        do_op(8'h20, 1, 0);
        hit <= 1'b0;
        chk1("latch after erase", 1'b0, latch);
        srp0 <= 1'b1;
        do_op(8'h06, 1, 0);
        host.io[2] <= 1'b0;
        do_op(8'h01, 1, 0);
        host.io[2] <= 1'b1;
        srp0 <= 1'b0;
        chk("permits", 8'h01, 8'(gos));
        do_op(8'h06, 1, 0);
        host.cut(8'h06);
        do_op(8'h04, 1, 0);
        chk1("latch after disable", 1'b0, latch);
        do_op(8'h38, 0, 0);
        do_op(8'h6b, 0, 0);
        qe <= 1'b1;
        foreach (rd[i]) do_op(rd[i], 1, 0);
        srp0 <= 1'b1;
        do_op(8'h06, 1, 0);
        host.io[2] <= 1'b0;
        do_op(8'h01, 1, 0);
        host.io[2] <= 1'b1;
        srp0 <= 1'b0;
        chk("permits with quad", 8'h02, 8'(gos));
        do_op(8'h38, 1, 0);
        chk1("four-wire mode", 1'b1, fw);
        do_op(8'h06, 1, 1);
        do_op(8'hff, 1, 1);
        chk1("serial mode", 1'b0, fw);
        do_op(8'h38, 1, 0);
        do_op(8'h66, 1, 1);
        do_op(8'h99, 1, 1);
        chk1("resetting", 1'b1, busy);
        chk1("standby in reset", 1'b0, stby);
        chk1("mode after reset", 1'b0, fw);
        chk1("latch after reset", 1'b0, latch);
        do_op(8'h06, 0, 0);
        repeat (300) @(posedge ref_clk);
        do_op(8'hb9, 1, 0);
        chk1("deep entered", 1'b1, deep);
        do_op(8'h06, 0, 0);
        do_op(8'hab, 1, 0);
        chk1("deep down", 1'b0, deep);
        host.hold(1'b0, 1'b0);
        chk1("pause with quad", 1'b0, paused);
        chk1("selected", 1'b1, sel);
        host.hold(1'b1, 1'b1);
        qe <= 1'b0;
        host.hold(1'b0, 1'b0);
        chk1("paused", 1'b1, paused);
        host.hold(1'b0, 1'b1);
        chk1("pause after deselect", 1'b0, paused);
        host.hold(1'b1, 1'b1);
        pcs <= 1'b1;
        do_op(8'h06, 1, 0);
        host.hold(1'b0, 1'b1);
        do_op(8'h06, 0, 0);
        repeat (100) @(posedge ref_clk);
        chk1("latch after pin reset", 1'b0, latch);
        host.hold(1'b1, 1'b1);
        chk("pending", 8'h00, 8'(exp_q.size()));
        end_sim();
    end
endmodule // sfmc_tb_top
